// ==== common/asp_consts.vh ====
// Purpose: Constants of the audio serial port
// Assumes: 40 MHz system clock
// Notes:   Included by every design file of the block
`ifndef ASP_CONSTS_VH
`define ASP_CONSTS_VH

// ****************************************
// Timing
// ****************************************
`define ASP_CLK_HZ        40000000
`define ASP_FS_MAX_HZ     48000
`define ASP_SLOT_BITS     32
// Bit clock half period, rounded up so the frame rate stays at or under the limit
`define ASP_BCLK_HALF     ((`ASP_CLK_HZ + 2 * 2 * `ASP_SLOT_BITS * `ASP_FS_MAX_HZ - 1) / (2 * 2 * `ASP_SLOT_BITS * `ASP_FS_MAX_HZ))
// Shortest legal frame in system clocks
`define ASP_FRAME_MIN     (`ASP_CLK_HZ / `ASP_FS_MAX_HZ)
`define ASP_MCLK_HALF     2

// ****************************************
// Encodings
// ****************************************
`define ASP_FMT_STD       2'h0
`define ASP_FMT_LEFT      2'h1
`define ASP_FMT_RIGHT     2'h2
`define ASP_WID_8         2'h0
`define ASP_WID_16        2'h1
`define ASP_WID_24        2'h2

// ****************************************
// Buffer
// ****************************************
`define ASP_SAMPLE_W      24
`define ASP_FIFO_DEPTH    8
`define ASP_FIFO_AW       3

`endif

// ==== rtl/asp_fifo.v ====
// Purpose: Sample FIFO with valid/ready on both sides
// Assumes: One clock, asynchronous active-high reset
// Notes:   DEPTH must equal 2**AW
`timescale 1ns/1ps
`include "asp_consts.vh"

module asp_fifo #(
	parameter WIDTH = `ASP_SAMPLE_W,
	parameter DEPTH = `ASP_FIFO_DEPTH,
	parameter AW    = `ASP_FIFO_AW
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;

	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;

	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];

	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
			end
			if (push & ~pop) begin
				count <= count + {{AW{1'b0}}, 1'b1};
			end else if (pop & ~push) begin
				count <= count - {{AW{1'b0}}, 1'b1};
			end
		end
	end

endmodule // asp_fifo

// ==== rtl/asp_core.v ====
// Purpose: Full-duplex audio serial port, master or slave
// Assumes: Config inputs come from logic on clk and change only while idle
// Notes:   Every slot is 32 bit clocks wide; two slots per frame
`timescale 1ns/1ps
`include "asp_consts.vh"

module asp_core (
	input  wire        clk,
	input  wire        rst,
	input  wire        cfg_master,
	input  wire [1:0]  cfg_format,
	input  wire [1:0]  cfg_width,
	input  wire        cfg_mclk_en,
	input  wire [23:0] tx_data,
	input  wire        tx_valid,
	output wire        tx_ready,
	output reg  [23:0] rx_data,
	output reg         rx_right,
	output reg         rx_valid,
	output reg         tx_underrun,
	output reg         rate_fault,
	output reg         master_clock_out,
	input  wire        bit_clock_in,
	output reg         bit_clock_out,
	output wire        bit_clock_oe,
	input  wire        word_select_clock_in,
	output reg         word_select_clock_out,
	output wire        word_select_clock_oe,
	input  wire        serial_data_in,
	output reg         serial_data_out
);

	localparam [31:0] BCLK_HALF_W  = `ASP_BCLK_HALF - 1;
	localparam [31:0] FRAME_MIN_W  = `ASP_FRAME_MIN;
	localparam [31:0] MCLK_HALF_W  = `ASP_MCLK_HALF - 1;
	localparam [7:0]  BCLK_HALF_M1 = BCLK_HALF_W[7:0];
	localparam [9:0]  FRAME_MIN    = FRAME_MIN_W[9:0];
	localparam [3:0]  MCLK_HALF_M1 = MCLK_HALF_W[3:0];
	// ****************************************
	// Helpers
	// ****************************************
	function [5:0] width_bits;
		input [1:0] wsel;
		begin
			case (wsel)
				`ASP_WID_8:  width_bits = 6'h08;
				`ASP_WID_16: width_bits = 6'h10;
				default:     width_bits = 6'h18;
			endcase
		end
	endfunction
	function [5:0] data_offset;
		input [1:0] fmt;
		input [1:0] wsel;
		begin
			case (fmt)
				`ASP_FMT_LEFT:  data_offset = 6'h00;
				`ASP_FMT_RIGHT: data_offset = 6'h20 - width_bits(wsel);
				default:        data_offset = 6'h01;
			endcase
		end
	endfunction
	function in_data;
		input [5:0] c;
		input [1:0] fmt;
		input [1:0] wsel;
		reg [5:0] p;
		begin
			p = c - data_offset(fmt, wsel);
			in_data = (c >= data_offset(fmt, wsel)) && (p < width_bits(wsel));
		end
	endfunction
	// MSB-first bit of a left-aligned word at slot position c
	function tx_bit;
		input [23:0] word;
		input [5:0]  c;
		input [1:0]  fmt;
		input [1:0]  wsel;
		reg [5:0] p;
		begin
			p = c - data_offset(fmt, wsel);
			if (in_data(c, fmt, wsel)) begin
				tx_bit = word[5'h17 - p[4:0]];
			end else begin
				tx_bit = 1'b0;
			end
		end
	endfunction
	function [23:0] align_left;
		input [23:0] d;
		input [1:0]  wsel;
		begin
			case (wsel)
				`ASP_WID_8:  align_left = {d[7:0], 16'h0000};
				`ASP_WID_16: align_left = {d[15:0], 8'h00};
				default:     align_left = d;
			endcase
		end
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	reg [1:0] bck_sync;
	reg [1:0] ws_sync;
	reg [1:0] sdi_sync;
	reg       bck_last;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			bck_sync <= 2'h0;
			ws_sync  <= 2'h0;
			sdi_sync <= 2'h0;
			bck_last <= 1'b0;
		end else begin
			bck_sync <= {bck_sync[0], bit_clock_in};
			ws_sync  <= {ws_sync[0], word_select_clock_in};
			sdi_sync <= {sdi_sync[0], serial_data_in};
			bck_last <= bck_sync[1];
		end
	end
	wire ext_rise = bck_sync[1] & ~bck_last;
	wire ext_fall = ~bck_sync[1] & bck_last;

	// ****************************************
	// Master clock generation
	// ****************************************
	reg [7:0] div_cnt;
	reg [5:0] fcnt;
	wire      int_tick  = (div_cnt == BCLK_HALF_M1);
	wire      int_rise  = cfg_master & int_tick & ~bit_clock_out;
	wire      int_fall  = cfg_master & int_tick & bit_clock_out;
	wire [5:0] next_fcnt = fcnt + 6'h01;
	assign bit_clock_oe         = cfg_master;
	assign word_select_clock_oe = cfg_master;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			div_cnt               <= 8'h00;
			bit_clock_out         <= 1'b0;
			fcnt                  <= 6'h00;
			word_select_clock_out <= 1'b0;
		end else if (!cfg_master) begin
			div_cnt               <= 8'h00;
			bit_clock_out         <= 1'b0;
			fcnt                  <= 6'h00;
			word_select_clock_out <= 1'b0;
		end else begin
			div_cnt <= int_tick ? 8'h00 : div_cnt + 8'h01;
			if (int_tick) begin
				bit_clock_out <= ~bit_clock_out;
			end
			if (int_fall) begin
				fcnt                  <= next_fcnt;
				word_select_clock_out <= next_fcnt[5];
			end
		end
	end

	// Runs regardless of mode so parts without a reference can be fed
	reg [3:0] mdiv;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mdiv             <= 4'h0;
			master_clock_out <= 1'b0;
		end else if (!cfg_mclk_en) begin
			mdiv             <= 4'h0;
			master_clock_out <= 1'b0;
		end else if (mdiv == MCLK_HALF_M1) begin
			mdiv             <= 4'h0;
			master_clock_out <= ~master_clock_out;
		end else begin
			mdiv <= mdiv + 4'h1;
		end
	end

	// ****************************************
	// Slot tracking
	// ****************************************
	wire rise   = cfg_master ? int_rise : ext_rise;
	wire fall   = cfg_master ? int_fall : ext_fall;
	wire ws_cur = cfg_master ? next_fcnt[5] : ws_sync[1];
	reg       ws_last;
	reg [5:0] cnt;
	reg       synced;
	reg       chan;
	wire       slot_start = fall & (ws_cur != ws_last);
	wire [5:0] next_cnt   = slot_start ? 6'h00 : ((cnt == 6'h3F) ? cnt : cnt + 6'h01);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ws_last <= 1'b0;
			cnt     <= 6'h3F;
			synced  <= 1'b0;
			chan    <= 1'b0;
		end else if (fall) begin
			ws_last <= ws_cur;
			cnt     <= next_cnt;
			if (slot_start) begin
				synced <= 1'b1;
				chan   <= ws_cur;
			end
		end
	end

	// ****************************************
	// Transmit path
	// ****************************************
	wire [23:0] fifo_data;
	wire        fifo_valid;
	wire        fifo_pop = slot_start; // Drain stalls between slots, so the FIFO can fill
	wire [23:0] load_word = fifo_valid ? align_left(fifo_data, cfg_width) : 24'h000000;
	reg  [23:0] tx_word;
	asp_fifo #(
		.WIDTH (`ASP_SAMPLE_W),
		.DEPTH (`ASP_FIFO_DEPTH),
		.AW    (`ASP_FIFO_AW)
	) u_tx_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_data   (tx_data),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);
	// Updated on the falling edge so the bit is stable for the next rising edge
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_word         <= 24'h000000;
			serial_data_out <= 1'b0;
			tx_underrun     <= 1'b0;
		end else begin
			tx_underrun <= slot_start & ~fifo_valid;
			if (slot_start) begin
				tx_word         <= load_word;
				serial_data_out <= tx_bit(load_word, next_cnt, cfg_format, cfg_width);
			end else if (fall) begin
				serial_data_out <= synced & tx_bit(tx_word, next_cnt, cfg_format, cfg_width);
			end
		end
	end

	// ****************************************
	// Receive path
	// ****************************************
	reg [23:0] rx_shift;
	wire [5:0] rx_pos  = cnt - data_offset(cfg_format, cfg_width);
	wire       rx_take = rise & synced & in_data(cnt, cfg_format, cfg_width);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_shift <= 24'h000000;
			rx_data  <= 24'h000000;
			rx_right <= 1'b0;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (slot_start) begin
				rx_shift <= 24'h000000;
			end else if (rx_take) begin
				rx_shift <= {rx_shift[22:0], sdi_sync[1]};
				if (rx_pos == width_bits(cfg_width) - 6'h01) begin
					rx_data  <= {rx_shift[22:0], sdi_sync[1]};
					rx_right <= chan;
					rx_valid <= 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Frame rate watch, slave only
	// ****************************************
	// Master timing meets the limit by construction
	reg [9:0] frame_cnt;
	reg       frame_seen;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_cnt  <= 10'h000;
			frame_seen <= 1'b0;
			rate_fault <= 1'b0;
		end else begin
			rate_fault <= 1'b0;
			if (cfg_master) begin
				frame_cnt  <= 10'h000;
				frame_seen <= 1'b0;
			end else if (slot_start & ~ws_cur) begin
				rate_fault <= frame_seen & (frame_cnt < FRAME_MIN);
				frame_cnt  <= 10'h000;
				frame_seen <= 1'b1;
			end else if (frame_cnt != 10'h3FF) begin
				frame_cnt <= frame_cnt + 10'h001;
			end
		end
	end

endmodule // asp_core

// ==== testbench/asp_core_asserts.sv ====
// Purpose: Port checks of the audio serial port
// Assumes: Bound to asp_core; bit clock half period of 7 clocks
// Notes:   Master clock toggles every 2 clocks
`timescale 1ns/1ps
`include "asp_consts.vh"
module asp_core_chk (
	input wire        clk,
	input wire        rst,
	input wire        cfg_master,
	input wire [1:0]  cfg_width,
	input wire        cfg_mclk_en,
	input wire        tx_ready,
	input wire [23:0] rx_data,
	input wire        rx_right,
	input wire        rx_valid,
	input wire        tx_underrun,
	input wire        rate_fault,
	input wire        master_clock_out,
	input wire        bit_clock_out,
	input wire        bit_clock_oe,
	input wire        word_select_clock_out,
	input wire        word_select_clock_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	reg       had_rx;
	reg       last_right;
	reg [2:0] up;
	// Past samples reach back into reset just after reset
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			had_rx <= 1'b0;
			last_right <= 1'b0;
			up <= 3'h0;
		end else begin
			if (up != 3'h7)
				up <= up + 3'h1;
			if (rx_valid) begin
				had_rx <= 1'b1;
				last_right <= rx_right;
			end
		end
	end
	AST_OE: assert property (bit_clock_oe == cfg_master && word_select_clock_oe == cfg_master)
		else $error("clock enables off mode");
	AST_SLAVE_QUIET: assert property (!cfg_master |-> !bit_clock_out && !word_select_clock_out)
		else $error("slave drives clocks");
	AST_BCLK_HALF: assert property ($rose(bit_clock_out) |-> bit_clock_out[*7] ##1 !bit_clock_out)
		else $error("bit clock half period");
	AST_WS_AT_FALL: assert property ($changed(word_select_clock_out) |-> $fell(bit_clock_out))
		else $error("word select off fall");
	AST_MCLK_RUN: assert property (up == 3'h7 && cfg_mclk_en && $past(cfg_mclk_en, 2)
		|-> master_clock_out != $past(master_clock_out, 2))
		else $error("master clock stuck");
	AST_MCLK_OFF: assert property (!cfg_mclk_en && !$past(cfg_mclk_en) |-> !master_clock_out)
		else $error("master clock while off");
	AST_RX_PULSE: assert property (rx_valid |=> !rx_valid[*8])
		else $error("receive pulse too close");
	AST_RX_ALT: assert property (rx_valid && had_rx |-> rx_right != last_right)
		else $error("channel not alternating");
	AST_RX_WIDTH: assert property (rx_valid |->
		!((cfg_width == `ASP_WID_8 && rx_data[23:8] != 16'h0)
		|| (cfg_width == `ASP_WID_16 && rx_data[23:16] != 8'h0)))
		else $error("receive word too wide");
	AST_RATE_MASTER: assert property (cfg_master |-> !rate_fault)
		else $error("rate fault as master");
	cover property (rx_valid && rx_right);
	cover property (rate_fault);
	cover property (tx_underrun);
	cover property (!tx_ready);
endmodule // asp_core_chk

// ==== testbench/asp_codec.sv ====
// Purpose: Codec model on the far side of the port
// Assumes: Loops data back; 200 ns bit clock when it is master
// Notes:   Clocks stand still between frames unless fast is set
`timescale 1ns/1ps
module asp_codec (
	input  wire        drive,
	input  wire        fast,
	input  wire        bclk,
	input  wire        ws,
	input  wire        sdo,
	output reg         c_bclk,
	output reg         c_ws,
	output wire        sdi,
	output reg  [31:0] got
);
	reg [31:0] sr;
	reg        wsp;
	integer    i;
	assign sdi = sdo;
	initial begin
		c_bclk = 1'b0;
		c_ws = 1'b0;
		sr = 32'h0;
		got = 32'h0;
		wsp = 1'b0;
		forever begin
			if (drive) begin
				for (i = 0; i < 64; i = i + 1) begin
					#100 c_bclk = 1'b1;
					#100 c_bclk = 1'b0;
					c_ws = ((i + 1) % 64) >= 32;
				end
				// Pause keeps the frame rate legal
				if (!fast)
					#9000;
			end else
				#25;
		end
	end
	// Sample on the rising edge; the falling edge races the data change
	always @(posedge bclk) begin
		sr  <= {sr[30:0], sdo};
		wsp <= ws;
		if (ws != wsp)
			got <= sr;
	end
endmodule // asp_codec

// ==== testbench/tb_audio_serial_port_master_slave.sv ====
// Purpose: Self-checking bench of the audio serial port
// Assumes: Codec loops data back
// Notes:   Config changes only under reset
`timescale 1ns/1ps
module tb_audio_serial_port_master_slave;
	localparam logic [23:0] D = 24'hB4E2D9;
	logic        clk = 1'b0, rst = 1'b1, cfg_master = 1'b1, cfg_mclk_en = 1'b0;
	logic [1:0]  cfg_format = 2'h0, cfg_width = 2'h0;
	logic [23:0] tx_data = 24'h0;
	logic        tx_valid = 1'b0, drive = 1'b0, fast = 1'b0, rf_seen;
	wire  [23:0] rx_data;
	wire  [31:0] got;
	wire         tx_ready, rx_right, rx_valid, tx_underrun, rate_fault, master_clock_out;
	wire         bit_clock_out, bit_clock_oe, word_select_clock_out, word_select_clock_oe;
	wire         serial_data_out, serial_data_in, c_bclk, c_ws;
	wire         bit_clock_in, word_select_clock_in;
	int          n_mismatch = 0, checks = 0;
	assign bit_clock_in = bit_clock_oe ? bit_clock_out : c_bclk;
	assign word_select_clock_in = word_select_clock_oe ? word_select_clock_out : c_ws;
	asp_core u_dut (
		.clk                   (clk),
		.rst                   (rst),
		.cfg_master            (cfg_master),
		.cfg_format            (cfg_format),
		.cfg_width             (cfg_width),
		.cfg_mclk_en           (cfg_mclk_en),
		.tx_data               (tx_data),
		.tx_valid              (tx_valid),
		.tx_ready              (tx_ready),
		.rx_data               (rx_data),
		.rx_right              (rx_right),
		.rx_valid              (rx_valid),
		.tx_underrun           (tx_underrun),
		.rate_fault            (rate_fault),
		.master_clock_out      (master_clock_out),
		.bit_clock_in          (bit_clock_in),
		.bit_clock_out         (bit_clock_out),
		.bit_clock_oe          (bit_clock_oe),
		.word_select_clock_in  (word_select_clock_in),
		.word_select_clock_out (word_select_clock_out),
		.word_select_clock_oe  (word_select_clock_oe),
		.serial_data_in        (serial_data_in),
		.serial_data_out       (serial_data_out)
	);
	asp_codec u_codec (.drive(drive), .fast(fast), .bclk(bit_clock_in),
		.ws(word_select_clock_in), .sdo(serial_data_out), .c_bclk(c_bclk), .c_ws(c_ws),
		.sdi(serial_data_in), .got(got));
	always @(posedge clk or posedge rst)
		if (rst)
			rf_seen <= 1'b0;
		else if (rate_fault)
			rf_seen <= 1'b1;
	task automatic check(input logic [31:0] a, input logic [31:0] e);
		checks++;
		if (a !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: %h not %h", $time, a, e);
		end
	endtask
	task automatic restart(input logic m, input logic [1:0] f, input logic [1:0] w);
		@(negedge clk);
		rst = 1'b1;
		tx_valid = 1'b0;
		drive = !m;
		cfg_master = m;
		cfg_format = f;
		cfg_width = w;
		cfg_mclk_en = !(m & w[1]);
		repeat (5) @(negedge clk);
		check({rx_valid, master_clock_out, bit_clock_out, serial_data_out}, 0);
		check(bit_clock_oe, m);
		rst = 1'b0;
		tx_data = D;
		tx_valid = 1'b1;
	endtask
	task automatic t_mode(input logic m, input logic [1:0] f, input logic [1:0] w);
		int wb;
		logic [31:0] dm;
		wb = (w == 2'h0) ? 8 : (w == 2'h1) ? 16 : 24;
		dm = D & ((32'h1 << wb) - 1);
		restart(m, f, w);
		repeat (4000) @(negedge clk);
		check(got, f == 2'h1 ? dm << (32 - wb) : f == 2'h2 ? dm : dm << (31 - wb));
		check(rx_data, dm);
		check(rf_seen, 0);
	endtask
	task automatic t_fifo;
		int k;
		restart(1'b1, 2'h0, 2'h1);
		repeat (12) @(negedge clk);
		check(tx_ready, 0);
		tx_valid = 1'b0;
		k = 0;
		while (tx_underrun !== 1'b1 && k < 5000) begin
			@(negedge clk);
			k++;
		end
		check(tx_underrun, 1);
		check(k > 3500, 1);
	endtask
	task automatic t_fast;
		fast = 1'b1;
		restart(1'b0, 2'h0, 2'h2);
		repeat (4000) @(negedge clk);
		check(rf_seen, 1);
		fast = 1'b0;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial forever #12.5 clk = ~clk;
	initial begin
		// About 68000 cycles of tests, with margin
		repeat (80000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end
	initial begin
		for (int f = 0; f < 4; f++)
			for (int w = 0; w < 3; w++)
				t_mode(1'b1, f[1:0], w[1:0]);
		for (int s = 0; s < 3; s++)
			t_mode(1'b0, s[1:0], 2'h2 - s[1:0]);
		t_fifo();
		t_fast();
		print_verdict();
	end
endmodule // tb_audio_serial_port_master_slave
bind asp_core asp_core_chk u_chk (
	.clk                   (clk),
	.rst                   (rst),
	.cfg_master            (cfg_master),
	.cfg_width             (cfg_width),
	.cfg_mclk_en           (cfg_mclk_en),
	.tx_ready              (tx_ready),
	.rx_data               (rx_data),
	.rx_right              (rx_right),
	.rx_valid              (rx_valid),
	.tx_underrun           (tx_underrun),
	.rate_fault            (rate_fault),
	.master_clock_out      (master_clock_out),
	.bit_clock_out         (bit_clock_out),
	.bit_clock_oe          (bit_clock_oe),
	.word_select_clock_out (word_select_clock_out),
	.word_select_clock_oe  (word_select_clock_oe)
);
